// file: design/phy_err_led_consts.vh
// Constants for the error counter and lamp select register block
`ifndef PHY_ERR_LED_CONSTS_VH
`define PHY_ERR_LED_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses (5-bit management register number)
// ----------------------------------------------------------------
`define ADDR_RX_ERROR_FRAME_COUNT      5'h15
`define ADDR_RX_SYMBOL_ERROR_COUNT     5'h16
`define ADDR_RX_EARLY_FRAME_END_COUNT  5'h17
`define ADDR_RX_10M_FRAME_END_ERR_CNT  5'h18
`define ADDR_TX_10M_JABBER_COUNT       5'h19
`define ADDR_EQUALIZER_RESERVED        5'h1a
`define ADDR_LED_SOURCE_SELECT         5'h1b

// ----------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------
`define LED_SEL_MSB                    2
`define LED_SEL_LSB                    0
`define LED_SEL_RESET                  3'h0
`define CNT_RESET                      16'h0000
`define CNT_FULL                       16'hffff
`define EQ_RESET                       16'h0000
`define SYM_RUN_LEN                    3'h6

`endif

// file: design/phy_error_counters_led_ctrl.v
// Error counters and lamp source select for the PHY management space
//
// Operation
// - Error frame counter adds one per frame holding a symbol error or a premature end.
// - All five counters stop at all ones instead of wrapping.
// - Reading a counter returns its value, then clears it.
// - Symbol errors count; a run of consecutive bad symbols adds one per started group of six.
// - Premature frame end counter adds one per premature end event.
// - 10 Mb end-of-frame error counter adds one per event.
// - 10 Mb jabber counter adds one per jabber detection.
`timescale 1ns/1ns
`default_nettype none
`include "phy_err_led_consts.vh"

module phy_error_counters_led_ctrl (
    input  wire        clk,
    input  wire        rst,
    input  wire [4:0]  reg_addr,
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata_ff,
    output reg         reg_rvalid_ff,
    input  wire        rx_frame_active,
    input  wire        rx_symbol_error,
    input  wire        rx_early_end,
    input  wire        rx_10m_frame_end_error,
    input  wire        tx_10m_jabber,
    input  wire        ind_activity,
    input  wire        ind_link,
    input  wire        ind_speed,
    input  wire        ind_collision,
    output reg         activity_lamp_out,
    output reg         link_lamp_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [2:0]  led_sel_ff;
    reg  [15:0] eq_ff;
    reg         frame_err_seen_ff;
    reg  [2:0]  sym_run_ff;
    wire [15:0] cnt_frame;
    wire [15:0] cnt_sym;
    wire [15:0] cnt_early;
    wire [15:0] cnt_eof10;
    wire [15:0] cnt_jab;
    wire        frame_err_inc;
    wire        sym_inc;
    wire        frame_err_now;

    // Read strobes per counter; other addresses leave the counters alone
    wire rd_frame = reg_rd && reg_addr == `ADDR_RX_ERROR_FRAME_COUNT;
    wire rd_sym   = reg_rd && reg_addr == `ADDR_RX_SYMBOL_ERROR_COUNT;
    wire rd_early = reg_rd && reg_addr == `ADDR_RX_EARLY_FRAME_END_COUNT;
    wire rd_eof10 = reg_rd && reg_addr == `ADDR_RX_10M_FRAME_END_ERR_CNT;
    wire rd_jab   = reg_rd && reg_addr == `ADDR_TX_10M_JABBER_COUNT;

    // ------------------------------------------------------------
    // Per-frame error detection
    // ------------------------------------------------------------
    // First error of a frame counts; further errors are absorbed
    assign frame_err_now = rx_frame_active && (rx_symbol_error || rx_early_end);
    assign frame_err_inc = frame_err_now && !frame_err_seen_ff;

    // Seen flag drops between frames so the next frame can count again
    always @(posedge clk) begin
        if (rst) begin
            frame_err_seen_ff <= 1'b0;
        end else if (!rx_frame_active) begin
            frame_err_seen_ff <= 1'b0;
        end else if (frame_err_now) begin
            frame_err_seen_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Symbol error run grouping
    // ------------------------------------------------------------
    // Count on the first bad symbol of each group of six in a row
    assign sym_inc = rx_symbol_error && sym_run_ff == 3'h0;

    // Position in the run; a gap in the strobes restarts the grouping
    always @(posedge clk) begin
        if (rst) begin
            sym_run_ff <= 3'h0;
        end else if (!rx_symbol_error) begin
            sym_run_ff <= 3'h0;
        end else if (sym_run_ff == `SYM_RUN_LEN - 3'h1) begin
            sym_run_ff <= 3'h0;
        end else begin
            sym_run_ff <= sym_run_ff + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    // One saturating clear-on-read counter per event source
    // A read and an event in one cycle leave the count at one
    sat_rc_counter u_cnt_frame (
        .clk      (clk),
        .rst      (rst),
        .inc      (frame_err_inc),
        .rd_clr   (rd_frame),
        .count_ff (cnt_frame)
    );

    sat_rc_counter u_cnt_sym (
        .clk      (clk),
        .rst      (rst),
        .inc      (sym_inc),
        .rd_clr   (rd_sym),
        .count_ff (cnt_sym)
    );

    sat_rc_counter u_cnt_early (
        .clk      (clk),
        .rst      (rst),
        .inc      (rx_early_end),
        .rd_clr   (rd_early),
        .count_ff (cnt_early)
    );

    sat_rc_counter u_cnt_eof10 (
        .clk      (clk),
        .rst      (rst),
        .inc      (rx_10m_frame_end_error),
        .rd_clr   (rd_eof10),
        .count_ff (cnt_eof10)
    );

    sat_rc_counter u_cnt_jab (
        .clk      (clk),
        .rst      (rst),
        .inc      (tx_10m_jabber),
        .rd_clr   (rd_jab),
        .count_ff (cnt_jab)
    );

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    // Lamp select keeps only its select field, reserved bits are dropped; the equalizer register stores all 16 bits
    always @(posedge clk) begin
        if (rst) begin
            led_sel_ff <= `LED_SEL_RESET;
            eq_ff      <= `EQ_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_LED_SOURCE_SELECT) begin
                led_sel_ff <= reg_wdata[`LED_SEL_MSB:`LED_SEL_LSB];
            end
            if (reg_addr == `ADDR_EQUALIZER_RESERVED) begin
                eq_ff <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Value before the clear is returned one cycle after the strobe
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata_ff  <= 16'h0000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_RX_ERROR_FRAME_COUNT:     reg_rdata_ff <= cnt_frame;
                    `ADDR_RX_SYMBOL_ERROR_COUNT:    reg_rdata_ff <= cnt_sym;
                    `ADDR_RX_EARLY_FRAME_END_COUNT: reg_rdata_ff <= cnt_early;
                    `ADDR_RX_10M_FRAME_END_ERR_CNT: reg_rdata_ff <= cnt_eof10;
                    `ADDR_TX_10M_JABBER_COUNT:      reg_rdata_ff <= cnt_jab;
                    `ADDR_EQUALIZER_RESERVED:       reg_rdata_ff <= eq_ff;
                    `ADDR_LED_SOURCE_SELECT:
                        reg_rdata_ff <= {13'h0000, led_sel_ff};
                    default:                        reg_rdata_ff <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Lamp routing
    // ------------------------------------------------------------
    // Codes 000-011 route indications; 1xx forces the levels of bits 1:0
    // Lamps follow the indications one clock late
    always @(posedge clk) begin
        if (rst) begin
            activity_lamp_out <= 1'b0;
            link_lamp_out     <= 1'b0;
        end else begin
            case (led_sel_ff)
                3'h0: begin
                    activity_lamp_out <= ind_activity;
                    link_lamp_out     <= ind_link;
                end
                3'h1: begin
                    activity_lamp_out <= ind_speed;
                    link_lamp_out     <= ind_collision;
                end
                3'h2: begin
                    activity_lamp_out <= ind_speed;
                    link_lamp_out     <= ind_link;
                end
                3'h3: begin
                    activity_lamp_out <= ind_activity;
                    link_lamp_out     <= ind_collision;
                end
                default: begin
                    activity_lamp_out <= led_sel_ff[1];
                    link_lamp_out     <= led_sel_ff[0];
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// file: design/sat_rc_counter.v
// Saturating 16-bit counter that clears when read
`timescale 1ns/1ns
`default_nettype none
`include "phy_err_led_consts.vh"

module sat_rc_counter (
    input  wire        clk,
    input  wire        rst,
    input  wire        inc,
    input  wire        rd_clr,
    output reg  [15:0] count_ff
);

    // ------------------------------------------------------------
    // Counter update
    // ------------------------------------------------------------
    // A read clears; an event in the same cycle restarts at one
    always @(posedge clk) begin
        if (rst) begin
            count_ff <= `CNT_RESET;
        end else if (rd_clr) begin
            count_ff <= inc ? 16'h0001 : `CNT_RESET;
        end else if (inc && count_ff != `CNT_FULL) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

endmodule
`default_nettype wire

// file: tb/phy_err_led_checker.sv
// Assertion checker for the error counter and lamp select block
`timescale 1ns/1ns
`default_nettype none
module phy_err_led_checker (
    input wire        clk,
    input wire        rst,
    input wire [4:0]  reg_addr,
    input wire        reg_rd,
    input wire        reg_wr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata_ff,
    input wire        reg_rvalid_ff,
    input wire        rx_early_end,
    input wire        rx_10m_frame_end_error,
    input wire        tx_10m_jabber,
    input wire        activity_lamp_out,
    input wire        link_lamp_out
);
    // ----------------------------------------------------------------
    // Register port, counter and lamp properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rvalid; reg_rd |=> reg_rvalid_ff; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read got no answer");
    property p_novalid; !reg_rd |=> !reg_rvalid_ff; endproperty
    a_novalid: assert property (p_novalid) else $error("answer without read");
    property p_rsvd; reg_rd && reg_addr == 5'h1b |=> reg_rdata_ff[15:3] == 13'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("lamp select upper bits set");
    // Two reads two cycles apart with no event between: second reads zero
    property p_clr;
        reg_rd && reg_addr == 5'h19 && !tx_10m_jabber ##1 !tx_10m_jabber ##1 reg_rd && reg_addr == 5'h19
        |=> reg_rdata_ff == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("counter not cleared by read");
    // An event in the reading cycle survives the clear
    property p_early;
        reg_rd && reg_addr == 5'h17 && rx_early_end ##1 !rx_early_end ##1 reg_rd && reg_addr == 5'h17
        |=> reg_rdata_ff == 16'h0001;
    endproperty
    a_early: assert property (p_early) else $error("early end count wrong");
    property p_eof;
        reg_rd && reg_addr == 5'h18 && rx_10m_frame_end_error ##1 !rx_10m_frame_end_error
        ##1 reg_rd && reg_addr == 5'h18 |=> reg_rdata_ff == 16'h0001;
    endproperty
    a_eof: assert property (p_eof) else $error("frame end error count wrong");
    property p_jab;
        reg_rd && reg_addr == 5'h19 && tx_10m_jabber ##1 !tx_10m_jabber ##1 reg_rd && reg_addr == 5'h19
        |=> reg_rdata_ff == 16'h0001;
    endproperty
    a_jab: assert property (p_jab) else $error("jabber count wrong");
    property p_force;
        reg_wr && reg_addr == 5'h1b && reg_wdata[2] ##1 !reg_wr |=>
        activity_lamp_out == $past(reg_wdata[1], 2) && link_lamp_out == $past(reg_wdata[0], 2);
    endproperty
    a_force: assert property (p_force) else $error("forced lamp level wrong");
    c_sat: cover property (reg_rvalid_ff && reg_rdata_ff == 16'hffff);
    c_force: cover property (reg_wr && reg_addr == 5'h1b && reg_wdata[2]);
    c_jab: cover property (reg_rd && reg_addr == 5'h19 && tx_10m_jabber);
endmodule
bind phy_error_counters_led_ctrl phy_err_led_checker u_chk (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff), .rx_early_end(rx_early_end),
    .rx_10m_frame_end_error(rx_10m_frame_end_error), .tx_10m_jabber(tx_10m_jabber),
    .activity_lamp_out(activity_lamp_out), .link_lamp_out(link_lamp_out));
`default_nettype wire

// file: tb/phy_error_counters_led_ctrl_tb.sv
// Self-checking bench for the error counter and lamp select block
`timescale 1ns/1ns
`default_nettype none
module phy_error_counters_led_ctrl_tb;
    logic        clk, rst, reg_rd, reg_wr, frame_on;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [3:0]  ev, ind;
    wire  [15:0] rdata;
    wire         rvalid, act_lamp, link_lamp;
    integer      num_errors, total_checks, cyc, i;
    phy_error_counters_led_ctrl uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_ff(rdata),
        .reg_rvalid_ff(rvalid), .rx_frame_active(frame_on), .rx_symbol_error(ev[0]),
        .rx_early_end(ev[1]), .rx_10m_frame_end_error(ev[2]), .tx_10m_jabber(ev[3]),
        .ind_activity(ind[3]), .ind_link(ind[2]), .ind_speed(ind[1]), .ind_collision(ind[0]),
        .activity_lamp_out(act_lamp), .link_lamp_out(link_lamp));
    // ----------------------------------------------------------------
    // Access tasks and expected lamp levels
    // ----------------------------------------------------------------
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    // Read with optional events raised in the reading cycle
    task rd(input logic [4:0] a, input logic [15:0] exp, input logic [3:0] m);
        @(posedge clk) {reg_rd, reg_addr, ev} <= {1'b1, a, m};
        @(posedge clk) {reg_rd, ev} <= 5'h00;
        #1;
        chk("rvalid", 16'h0001, {15'h0, rvalid});
        chk("rdata", exp, rdata);
    endtask
    task burst(input logic [3:0] m, input integer n);
        @(posedge clk) ev <= m;
        repeat (n) @(posedge clk);
        ev <= 4'h0;
    endtask
    function automatic [1:0] lamp(input logic [2:0] c, input logic [3:0] s);
        case (c)
            3'h0: lamp = {s[3], s[2]};
            3'h1: lamp = {s[1], s[0]};
            3'h2: lamp = {s[1], s[2]};
            3'h3: lamp = {s[3], s[0]};
            default: lamp = c[1:0];
        endcase
    endfunction
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Clock, hang guard and test sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end
    initial begin
        {rst, reg_rd, reg_wr, frame_on, reg_addr, reg_wdata, ev, ind} = {4'h8, 29'h0};
        num_errors = 0;
        total_checks = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (i = 21; i < 28; i = i + 1) rd(i[4:0], 16'h0000, 4'h0);
        $display("test reset values done");
        for (i = 1; i < 4; i = i + 1) begin
            repeat (3) burst(4'h1 << i, 1);
            rd(5'h16 + i[4:0], 16'h0003, 4'h1 << i);
            rd(5'h16 + i[4:0], 16'h0001, 4'h0);
            rd(5'h16 + i[4:0], 16'h0000, 4'h0);
        end
        $display("test event counters done");
        @(posedge clk) frame_on <= 1'b1;
        burst(4'h1, 8);
        burst(4'h2, 1);
        @(posedge clk) frame_on <= 1'b0;
        @(posedge clk) frame_on <= 1'b1;
        burst(4'h1, 1);
        @(posedge clk) frame_on <= 1'b0;
        rd(5'h15, 16'h0002, 4'h0);
        rd(5'h16, 16'h0003, 4'h0);
        rd(5'h17, 16'h0001, 4'h0);
        $display("test frame errors done");
        for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk) ind <= i[0] ? 4'h5 : 4'ha;
            wr(5'h1b, {13'h0000, i[3:1]});
            repeat (2) @(posedge clk);
            #1;
            chk("lamps", {14'h0, lamp(i[3:1], ind)}, {14'h0, act_lamp, link_lamp});
            rd(5'h1b, {13'h0, i[3:1]}, 4'h0);
        end
        wr(5'h1a, 16'ha5c3);
        wr(5'h03, 16'hffff);
        rd(5'h1a, 16'ha5c3, 4'h0);
        rd(5'h03, 16'h0000, 4'h0);
        $display("test lamps and registers done");
        burst(4'h8, 65540);
        rd(5'h19, 16'hffff, 4'h0);
        rd(5'h19, 16'h0000, 4'h0);
        $display("test saturation done");
        conclude;
    end
endmodule
`default_nettype wire
